// *** hdl/tpmch_map.svh ***
// register offsets, field positions, reset values and timing counts of the timer channel block
`ifndef TPMCH_MAP_SVH
`define TPMCH_MAP_SVH
`define TPMCH_ADDR_W        4
`define TPMCH_OFF_MAIN_CTRL 4'h0
`define TPMCH_OFF_CH_CTRL   4'h1
`define TPMCH_OFF_VAL_HI    4'h2
`define TPMCH_OFF_VAL_LO    4'h3
`define TPMCH_OFF_MOD_HI    4'h4
`define TPMCH_OFF_MOD_LO    4'h5
`define TPMCH_OFF_CNT_HI    4'h6
`define TPMCH_OFF_CNT_LO    4'h7
`define TPMCH_OFF_PRESCALE  4'h8
// main control fields
`define TPMCH_MC_CENTER_PWM_SELECT      5
`define TPMCH_MC_CLKS_HI    4
`define TPMCH_MC_CLKS_LO    3
// channel control fields
`define TPMCH_CC_FLAG       7
`define TPMCH_CC_MSB        5
`define TPMCH_CC_MSA        4
`define TPMCH_CC_ELSB       3
`define TPMCH_CC_ELSA       2
`define TPMCH_RST_BYTE      8'h00
`define TPMCH_RST_WORD      16'h0000
`define TPMCH_FREE_TOP      16'hFFFF
`define TPMCH_CNT_ONE       16'h0001
`endif

// *** hdl/tpmch_pkg.sv ***
// types of the timer channel block
package tpmch_pkg;
   typedef enum logic [1:0] {
      TPMCH_CLK_OFF,
      TPMCH_CLK_BUS,
      TPMCH_CLK_FIXED,
      TPMCH_CLK_EXT
   } tpmch_clk_src_t;

   typedef enum logic [2:0] {
      TPMCH_MODE_IDLE,
      TPMCH_MODE_CAPTURE,
      TPMCH_MODE_COMPARE,
      TPMCH_MODE_EDGE_PWM,
      TPMCH_MODE_CENTER_PWM
   } tpmch_mode_t;

   // register port request
   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } tpmch_req_t;

   // channel pin outputs
   typedef struct packed {
      logic out;
      logic oe;
      logic owned;
   } tpmch_pin_t;
endpackage

// *** hdl/tpmch_top.sv ***
// timer channel: mode decode, coherent 16-bit value buffering and a shared counter
// Behaviour
// - edge-level 00 releases pin to other use
// - capture on rising, falling or both edges
// - compare: software, toggle, clear or set
// - edge PWM high-true or low-true pulses
// - center PWM ignores mode bits
// - 16-bit value register, reset zero
// - capture read latches both bytes coherently
// - control write clears coherency latches
// - writes ignored in capture mode
// - debug freezes read latches
// - debug reads return live register
// - compare writes buffered until both bytes
// - no clock: update on second byte
// - compare: update at next counter step
// - PWM: update when counter reaches modulo
// - debug writes go straight to register
// - debug writes keep partial sequence intact
// - one shared counter, prescaler and modulo
// - center select makes counter up/down
// - flag set by event, read-then-zero clears
// - clock select 00 off, else sources
`include "tpmch_map.svh"
`timescale 1ns/1ps
`default_nettype none
module tpmch_top #(
   parameter int PRESCALE_W = 3
) (
   input  wire logic               sys_clk_i,
   input  wire logic               sys_rst_i,
   input  wire tpmch_pkg::tpmch_req_t req_i,
   output var  logic [7:0]         rdata_o,
   input  wire logic               debug_i,
   input  wire logic               fixed_tick_i,
   input  wire logic               ext_clk_i,
   input  wire logic               ch_pin_i,
   output var  tpmch_pkg::tpmch_pin_t pin_o,
   output var  logic               flag_o
);
   import tpmch_pkg::*;

   // control and status state
   logic [7:0]  main_ctrl_q;
   logic [7:0]  ch_ctrl_q;
   logic [15:0] mod_q;
   logic [7:0]  mod_hi_buf_q;
   logic [15:0] cnt_q;
   logic        dir_down_q;
   logic [PRESCALE_W-1:0] pre_sel_q;
   logic [6:0]  pre_cnt_q;
   logic [15:0] val_q;
   logic [7:0]  wbuf_hi_q;
   logic [7:0]  wbuf_lo_q;
   logic        wgot_hi_q;
   logic        wgot_lo_q;
   logic        wpend_q;
   logic [15:0] rbuf_q;
   logic        rlatched_q;
   logic        flag_q;
   logic        flag_armed_q;
   logic [7:0]  rdata_q;
   logic        pin_sync1_q;
   logic        pin_sync2_q;
   logic        pin_prev_q;
   logic        ext_sync1_q;
   logic        ext_sync2_q;
   logic        ext_prev_q;
   logic        pin_out_q;
   tpmch_pin_t  pin_q;

   // field decode
   wire         center_pwm_select     = main_ctrl_q[`TPMCH_MC_CENTER_PWM_SELECT];
   wire [1:0]   clks      = main_ctrl_q[`TPMCH_MC_CLKS_HI:`TPMCH_MC_CLKS_LO];
   wire [1:0]   ms        = ch_ctrl_q[`TPMCH_CC_MSB:`TPMCH_CC_MSA];
   wire [1:0]   els       = ch_ctrl_q[`TPMCH_CC_ELSB:`TPMCH_CC_ELSA];
   wire         clk_on    = (tpmch_clk_src_t'(clks) != TPMCH_CLK_OFF);
   wire [15:0]  top       = mod_q;
   wire         top_free  = (mod_q == `TPMCH_RST_WORD);
   wire [15:0]  term      = top_free ? `TPMCH_FREE_TOP : top;

   // mode decode; center select overrides mode bits
   // edge-level 00 still decodes a mode; only the pin is handed back
   tpmch_mode_t mode;
   always_comb begin
      if (center_pwm_select) begin
         mode = TPMCH_MODE_CENTER_PWM;
      end else if (ms[1]) begin
         // edge PWM when mode bit b set
         mode = TPMCH_MODE_EDGE_PWM;
      end else if (ms[0]) begin
         mode = TPMCH_MODE_COMPARE;
      end else begin
         mode = TPMCH_MODE_CAPTURE;
      end
   end
   wire is_cap = (mode == TPMCH_MODE_CAPTURE);
   wire is_pwm = (mode == TPMCH_MODE_EDGE_PWM) || (mode == TPMCH_MODE_CENTER_PWM);

   // edge-level 00 hands the pin back
   wire pin_owned = (els != 2'b00);

   // bus strobes
   wire wr_main = req_i.wr && (req_i.addr == `TPMCH_OFF_MAIN_CTRL);
   wire wr_ch   = req_i.wr && (req_i.addr == `TPMCH_OFF_CH_CTRL);
   wire rd_ch   = req_i.rd && (req_i.addr == `TPMCH_OFF_CH_CTRL);
   wire wr_vhi  = req_i.wr && (req_i.addr == `TPMCH_OFF_VAL_HI);
   wire wr_vlo  = req_i.wr && (req_i.addr == `TPMCH_OFF_VAL_LO);
   wire rd_vhi  = req_i.rd && (req_i.addr == `TPMCH_OFF_VAL_HI);
   wire rd_vlo  = req_i.rd && (req_i.addr == `TPMCH_OFF_VAL_LO);
   wire wr_mhi  = req_i.wr && (req_i.addr == `TPMCH_OFF_MOD_HI);
   wire wr_mlo  = req_i.wr && (req_i.addr == `TPMCH_OFF_MOD_LO);
   wire wr_cnt  = req_i.wr && ((req_i.addr == `TPMCH_OFF_CNT_HI) || (req_i.addr == `TPMCH_OFF_CNT_LO));
   wire wr_pre  = req_i.wr && (req_i.addr == `TPMCH_OFF_PRESCALE);

   // clock source select; external edges are synchronised first
   // the external source must stay below a quarter of the bus rate,
   // or rising edges slip through the two-stage synchroniser unseen
   wire ext_rise = ext_sync2_q && !ext_prev_q;
   logic src_tick;
   always_comb begin
      case (tpmch_clk_src_t'(clks))
         TPMCH_CLK_BUS:   src_tick = 1'b1;
         TPMCH_CLK_FIXED: src_tick = fixed_tick_i;
         TPMCH_CLK_EXT:   src_tick = ext_rise;
         default:         src_tick = 1'b0;
      endcase
   end

   // prescaler divides by 2^sel; debug freezes the counter
   // limitation: the seven-bit prescale count caps the ratio at 128
   wire [6:0] pre_mask = 7'((8'h01 << pre_sel_q) - 8'h01);
   wire       cnt_tick = src_tick && !debug_i && ((pre_cnt_q & pre_mask) == pre_mask);

   // up counter, or up/down when center select set
   logic [15:0] cnt_d;
   logic        dir_d;
   always_comb begin
      cnt_d = cnt_q;
      dir_d = dir_down_q;
      if (!center_pwm_select) begin
         dir_d = 1'b0;
         cnt_d = (cnt_q >= term) ? `TPMCH_RST_WORD : cnt_q + `TPMCH_CNT_ONE;
      end else if (dir_down_q) begin
         if (cnt_q == `TPMCH_RST_WORD) begin
            dir_d = 1'b0;
            cnt_d = `TPMCH_CNT_ONE;
         end else begin
            cnt_d = cnt_q - `TPMCH_CNT_ONE;
         end
      end else if (cnt_q >= term) begin
         dir_d = 1'b1;
         cnt_d = cnt_q - `TPMCH_CNT_ONE;
      end else begin
         cnt_d = cnt_q + `TPMCH_CNT_ONE;
      end
   end

   // PWM reload point: counter steps into the terminal count
   // in free run the reload step is the one from 0xFFFE to 0xFFFF
   wire at_reload = cnt_tick && !dir_d && (cnt_d == term) && (cnt_q != term);

   // write buffer completes after both bytes
   wire wr_val_norm = (wr_vhi || wr_vlo) && !is_cap && !debug_i;
   wire both_done   = wr_val_norm && ((wr_vhi && wgot_lo_q) || (wr_vlo && wgot_hi_q));
   wire [15:0] wbuf_word = {wr_vhi ? req_i.wdata : wbuf_hi_q, wr_vlo ? req_i.wdata : wbuf_lo_q};
   // no clock: transfer at once; compare waits a counter step
   wire load_now  = both_done && !clk_on;
   wire pend_fire = wpend_q && (is_pwm ? at_reload : cnt_tick);

   // capture edge detection on synchronised pin
   wire rise = pin_sync2_q && !pin_prev_q;
   wire fall = !pin_sync2_q && pin_prev_q;
   wire cap_evt = is_cap && ((els[0] && rise) || (els[1] && fall));
   // match is taken as the counter steps onto the value, so the registered
   // pin moves together with the count, just as the period-start edge does
   wire match   = !is_cap && (cnt_d == val_q) && cnt_tick;
   wire ch_evt  = cap_evt || match;

   // pin synchronisers and edge history
   // no reset here: the chains flush long before the reset is released,
   // and a reset value could itself fake an edge on a pin that idles high
   always_ff @(posedge sys_clk_i) begin
      pin_sync1_q <= ch_pin_i;
      pin_sync2_q <= pin_sync1_q;
      pin_prev_q  <= pin_sync2_q;
      ext_sync1_q <= ext_clk_i;
      ext_sync2_q <= ext_sync1_q;
      ext_prev_q  <= ext_sync2_q;
   end

   // control, modulo and prescaler registers
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         main_ctrl_q  <= `TPMCH_RST_BYTE;
         ch_ctrl_q    <= `TPMCH_RST_BYTE;
         mod_q        <= `TPMCH_RST_WORD;
         mod_hi_buf_q <= `TPMCH_RST_BYTE;
         pre_sel_q    <= '0;
      end else begin
         if (wr_main) main_ctrl_q <= req_i.wdata;
         // flag bit lives in its own register
         if (wr_ch) ch_ctrl_q <= {1'b0, req_i.wdata[6:0]};
         if (wr_mhi) mod_hi_buf_q <= req_i.wdata;
         if (wr_mlo) mod_q <= {mod_hi_buf_q, req_i.wdata};
         if (wr_pre) pre_sel_q <= req_i.wdata[PRESCALE_W-1:0];
      end
   end

   // counter and prescaler; any count write restarts from zero
   // the prescale count restarts too, so the first step after a write is a full one
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i || wr_cnt) begin
         cnt_q      <= `TPMCH_RST_WORD;
         dir_down_q <= 1'b0;
         pre_cnt_q  <= '0;
      end else if (src_tick && !debug_i) begin
         pre_cnt_q <= pre_cnt_q + 7'h01;
         if (cnt_tick) begin
            cnt_q      <= cnt_d;
            dir_down_q <= dir_d;
         end
      end
   end

   // channel value register and write coherency
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         val_q     <= `TPMCH_RST_WORD;
         wbuf_hi_q <= `TPMCH_RST_BYTE;
         wbuf_lo_q <= `TPMCH_RST_BYTE;
         wgot_hi_q <= 1'b0;
         wgot_lo_q <= 1'b0;
         wpend_q   <= 1'b0;
      end else begin
         if (cap_evt) begin
            val_q <= cnt_q;
         end else if (!is_cap && debug_i && wr_vhi) begin
            val_q[15:8] <= req_i.wdata;
         end else if (!is_cap && debug_i && wr_vlo) begin
            val_q[7:0] <= req_i.wdata;
         end else if (load_now) begin
            val_q <= wbuf_word;
         end else if (pend_fire) begin
            val_q <= {wbuf_hi_q, wbuf_lo_q};
         end
         if (wr_val_norm && wr_vhi) wbuf_hi_q <= req_i.wdata;
         if (wr_val_norm && wr_vlo) wbuf_lo_q <= req_i.wdata;
         // control write clears write latches
         // a pair still waiting for its counter step is dropped as well,
         // so software rewrites both bytes after a mode change
         if (wr_ch) begin
            wgot_hi_q <= 1'b0;
            wgot_lo_q <= 1'b0;
            wpend_q   <= 1'b0;
         end else if (both_done) begin
            wgot_hi_q <= 1'b0;
            wgot_lo_q <= 1'b0;
            wpend_q   <= clk_on;
         end else begin
            if (wr_val_norm && wr_vhi) wgot_hi_q <= 1'b1;
            if (wr_val_norm && wr_vlo) wgot_lo_q <= 1'b1;
            if (pend_fire) wpend_q <= 1'b0;
         end
      end
   end

   // read latch: first byte read snapshots both bytes
   // the latch toggles on either byte, so reading one byte twice releases it
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         rbuf_q     <= `TPMCH_RST_WORD;
         rlatched_q <= 1'b0;
      end else if (wr_ch) begin
         rlatched_q <= 1'b0;
      end else if (is_cap && !debug_i && (rd_vhi || rd_vlo)) begin
         if (!rlatched_q) rbuf_q <= val_q;
         rlatched_q <= !rlatched_q;
      end
   end

   // flag: event sets, read-then-zero clears, set wins
   // an event inside the clear window keeps the flag, so no event is lost
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         flag_q       <= 1'b0;
         flag_armed_q <= 1'b0;
      end else if (ch_evt) begin
         flag_q       <= 1'b1;
         flag_armed_q <= 1'b0; // a new event restarts the clear sequence
      end else if (rd_ch && flag_q) begin
         flag_armed_q <= 1'b1;
      end else if (wr_ch && !req_i.wdata[`TPMCH_CC_FLAG]) begin
         if (flag_armed_q) flag_q <= 1'b0;
         flag_armed_q <= 1'b0;
      end
   end

   logic pin_out_d;
   always_comb begin
      pin_out_d = pin_out_q;
      case (mode)
         TPMCH_MODE_COMPARE: begin
            if (match) begin
               case (els)
                  2'b01:   pin_out_d = !pin_out_q;
                  2'b10:   pin_out_d = 1'b0;
                  2'b11:   pin_out_d = 1'b1;
                  default: pin_out_d = pin_out_q;
               endcase
            end
         end
         TPMCH_MODE_EDGE_PWM: begin
            // period start drives the active level, match ends it;
            // match goes first so a value of zero gives a flat inactive level
            if (match) pin_out_d = els[0];
            else if (cnt_tick && cnt_d == `TPMCH_RST_WORD) pin_out_d = !els[0];
         end
         TPMCH_MODE_CENTER_PWM: begin
            // active while count is below the value, either direction
            if (cnt_tick) pin_out_d = (cnt_d < val_q) ? !els[0] : els[0];
         end
         default: pin_out_d = pin_out_q;
      endcase
   end

   // read mux: capture reads use the latched snapshot outside debug
   // unmapped offsets read as zero rather than a stale byte
   wire [15:0] val_view = (is_cap && rlatched_q && !debug_i) ? rbuf_q : val_q;
   logic [7:0] rdata_d;
   always_comb begin
      case (req_i.addr)
         `TPMCH_OFF_MAIN_CTRL: rdata_d = main_ctrl_q;
         `TPMCH_OFF_CH_CTRL:   rdata_d = {flag_q, ch_ctrl_q[6:0]};
         `TPMCH_OFF_VAL_HI:    rdata_d = val_view[15:8];
         `TPMCH_OFF_VAL_LO:    rdata_d = val_view[7:0];
         `TPMCH_OFF_MOD_HI:    rdata_d = mod_q[15:8];
         `TPMCH_OFF_MOD_LO:    rdata_d = mod_q[7:0];
         `TPMCH_OFF_CNT_HI:    rdata_d = cnt_q[15:8];
         `TPMCH_OFF_CNT_LO:    rdata_d = cnt_q[7:0];
         `TPMCH_OFF_PRESCALE:  rdata_d = 8'(pre_sel_q);
         default:              rdata_d = `TPMCH_RST_BYTE;
      endcase
   end

   // outputs registered
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         rdata_q   <= `TPMCH_RST_BYTE;
         pin_out_q <= 1'b0;
         pin_q     <= '0;
      end else begin
         rdata_q   <= req_i.rd ? rdata_d : `TPMCH_RST_BYTE;
         pin_out_q <= pin_out_d;
         pin_q.out   <= pin_out_d;
         pin_q.oe    <= pin_owned && !is_cap;
         pin_q.owned <= pin_owned;
      end
   end

   assign rdata_o = rdata_q;
   assign pin_o   = pin_q;
   assign flag_o  = flag_q;
endmodule
`default_nettype wire

// *** test/tpmch_chk.sv ***
// concurrent checks on the timer channel ports
`include "tpmch_map.svh"
`timescale 1ns/1ps
`default_nettype none
module tpmch_chk (
   input wire logic                  sys_clk_i,
   input wire logic                  sys_rst_i,
   input wire tpmch_pkg::tpmch_req_t req_i,
   input wire logic                  ch_pin_i,
   input wire tpmch_pkg::tpmch_pin_t pin_o,
   input wire logic                  flag_o
);
   import tpmch_pkg::*;
   logic [3:0] cfg_q;
   logic [3:0] cfg_d;
   logic       cpw_q;
   logic       cpw_d;
   logic [1:0] age_q;
   logic [1:0] age_d;
   // shadow of the mode fields; age holds checks off until the registered pin outputs settle
   wire cc_wr  = req_i.wr && (req_i.addr == `TPMCH_OFF_CH_CTRL);
   wire mc_wr  = req_i.wr && (req_i.addr == `TPMCH_OFF_MAIN_CTRL);
   wire ready  = (age_q == 2'h3);
   wire els_on = (cfg_q[1:0] != 2'h0);
   wire cap    = ready && !cpw_q && (cfg_q[3:2] == 2'h0) && els_on;
   wire cmp    = ready && !cpw_q && (cfg_q[3:2] == 2'h1) && els_on;
   wire epw    = ready && !cpw_q && cfg_q[3] && els_on;
   wire cpw    = ready && cpw_q && els_on;
   assign cfg_d = cc_wr ? req_i.wdata[5:2] : cfg_q;
   assign cpw_d = mc_wr ? req_i.wdata[`TPMCH_MC_CENTER_PWM_SELECT] : cpw_q;
   assign age_d = (cc_wr || mc_wr) ? 2'h0 : (ready ? age_q : age_q + 2'h1);
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         cfg_q <= 4'h0;
         cpw_q <= 1'b0;
         age_q <= 2'h0;
      end else begin
         cfg_q <= cfg_d;
         cpw_q <= cpw_d;
         age_q <= age_d;
      end
   end
   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (sys_rst_i);
   // capture latency covers the two-stage synchroniser and the edge detector
   sequence s_flag_soon;
      ##[1:6] flag_o;
   endsequence
   property p_released;
      ready && !els_on |-> !pin_o.owned && !pin_o.oe;
   endproperty
   a_released: assert property (p_released) else $error("pin kept with edge-level off");
   property p_oe_owned;
      pin_o.oe |-> pin_o.owned;
   endproperty
   a_oe_owned: assert property (p_oe_owned) else $error("pin driven while released");
   property p_cap_quiet;
      cap |-> pin_o.owned && !pin_o.oe;
   endproperty
   a_cap_quiet: assert property (p_cap_quiet) else $error("capture pin driven");
   property p_cmp_drive;
      cmp |-> pin_o.owned && pin_o.oe;
   endproperty
   a_cmp_drive: assert property (p_cmp_drive) else $error("compare pin not driven");
   property p_edge_pwm_drive;
      epw ##1 epw |-> pin_o.oe && $stable(pin_o.oe);
   endproperty
   a_edge_pwm_drive: assert property (p_edge_pwm_drive) else $error("edge pwm pin not driven");
   property p_center_pwm_drive;
      cpw |-> pin_o.owned && pin_o.oe;
   endproperty
   a_center_pwm_drive: assert property (p_center_pwm_drive) else $error("center pwm pin not driven");
   property p_flag_hold;
      flag_o && !cc_wr |=> flag_o;
   endproperty
   a_flag_hold: assert property (p_flag_hold) else $error("flag dropped without control write");
   property p_flag_wr1;
      flag_o && cc_wr && req_i.wdata[`TPMCH_CC_FLAG] |=> flag_o;
   endproperty
   a_flag_wr1: assert property (p_flag_wr1) else $error("writing one cleared the flag");
   property p_cap_rise;
      cap && cfg_q[0] && $rose(ch_pin_i) && !flag_o |-> s_flag_soon;
   endproperty
   a_cap_rise: assert property (p_cap_rise) else $error("rising edge not captured");
   property p_cap_fall;
      cap && cfg_q[1] && $fell(ch_pin_i) && !flag_o |-> s_flag_soon;
   endproperty
   a_cap_fall: assert property (p_cap_fall) else $error("falling edge not captured");
endmodule
bind tpmch_top tpmch_chk u_chk (
   .sys_clk_i (sys_clk_i),
   .sys_rst_i (sys_rst_i),
   .req_i     (req_i),
   .ch_pin_i  (ch_pin_i),
   .pin_o     (pin_o),
   .flag_o    (flag_o)
);
`default_nettype wire

// *** test/tpmch_pin_model.sv ***
// channel pin driven from outside the block
`timescale 1ns/1ps
`default_nettype none
module tpmch_pin_model (
   input  wire logic lvl_i,
   output var  logic ch_pin_o
);
   // a 7 ns lag keeps pin edges away from the bus clock edge, at a fixed 7 ns after it
   initial ch_pin_o = 1'b0;
   always @(lvl_i) ch_pin_o <= #7 lvl_i;
endmodule
`default_nettype wire

// *** test/tpmch_top_tb.sv ***
// self-checking bench for the timer channel block
`include "tpmch_map.svh"
`timescale 1ns/1ps
`default_nettype none
module tpmch_top_tb;
   import tpmch_pkg::*;
   logic       clk;
   logic       rst;
   tpmch_req_t req;
   logic [7:0] rdata;
   logic       dbg;
   logic       ft;
   logic       ext;
   logic       lvl;
   logic       pin_in;
   tpmch_pin_t pin;
   logic       flag;
   int         fails = 0;
   int         total_checks = 0;
   tpmch_top #(.PRESCALE_W(3)) DUT (
      .sys_clk_i    (clk),
      .sys_rst_i    (rst),
      .req_i        (req),
      .rdata_o      (rdata),
      .debug_i      (dbg),
      .fixed_tick_i (ft),
      .ext_clk_i    (ext),
      .ch_pin_i     (pin_in),
      .pin_o        (pin),
      .flag_o       (flag)
   );
   tpmch_pin_model u_pin (
      .lvl_i    (lvl),
      .ch_pin_o (pin_in)
   );
   task automatic chk(input logic c, input string m);
      total_checks++;
      if (c !== 1'b1) begin
         fails++;
         $display("[FAIL] %0t %s", $time, m);
      end
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge clk);
   endtask
   // each access leaves one idle edge so no strobe is assigned twice in a time step
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      req <= '{addr: a, wdata: d, wr: 1'b0, rd: 1'b0};
      @(posedge clk);
   endtask
   task automatic rdc(input logic [3:0] a, input logic [7:0] e, input string m);
      req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b0};
      #1;
      chk(rdata === e, m);
      @(posedge clk);
   endtask
   task automatic clr(input logic [7:0] c);
      req <= '{addr: `TPMCH_OFF_CH_CTRL, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      wr(`TPMCH_OFF_CH_CTRL, c);
   endtask
   task automatic tick(input int n);
      repeat (n) begin
         ft <= 1'b1;
         @(posedge clk);
         ft <= 1'b0;
         @(posedge clk);
      end
   endtask
   task automatic pin_to(input logic v);
      idle(3);
      lvl <= v;
      idle(8);
   endtask
   task automatic t_reset;
      rdc(`TPMCH_OFF_VAL_HI, 8'h00, "high reset");
      rdc(`TPMCH_OFF_VAL_LO, 8'h00, "low reset");
      $display("reset test done");
   endtask
   task automatic t_compare;
      logic [7:0] cm [3] = '{8'h1C, 8'h18, 8'h14};
      logic       ce [3] = '{1'b1, 1'b0, 1'b1};
      wr(`TPMCH_OFF_MAIN_CTRL, 8'h00);
      wr(`TPMCH_OFF_CH_CTRL, 8'h14);
      wr(`TPMCH_OFF_VAL_HI, 8'h12);
      rdc(`TPMCH_OFF_VAL_HI, 8'h00, "half write landed");
      wr(`TPMCH_OFF_VAL_LO, 8'h34);
      rdc(`TPMCH_OFF_VAL_LO, 8'h34, "pair not committed");
      wr(`TPMCH_OFF_VAL_HI, 8'hAB);
      wr(`TPMCH_OFF_CH_CTRL, 8'h14);
      wr(`TPMCH_OFF_VAL_LO, 8'hCD);
      rdc(`TPMCH_OFF_VAL_HI, 8'h12, "latch kept");
      wr(`TPMCH_OFF_VAL_HI, 8'hEF);
      rdc(`TPMCH_OFF_VAL_HI, 8'hEF, "pair after latch reset");
      wr(`TPMCH_OFF_VAL_HI, 8'h11);
      dbg <= 1'b1;
      wr(`TPMCH_OFF_VAL_LO, 8'h22);
      rdc(`TPMCH_OFF_VAL_LO, 8'h22, "debug write held");
      dbg <= 1'b0;
      wr(`TPMCH_OFF_VAL_LO, 8'h33);
      rdc(`TPMCH_OFF_VAL_HI, 8'h11, "partial pair lost");
      wr(`TPMCH_OFF_MAIN_CTRL, 8'h10);
      wr(`TPMCH_OFF_VAL_HI, 8'h00);
      wr(`TPMCH_OFF_VAL_LO, 8'h02);
      rdc(`TPMCH_OFF_VAL_LO, 8'h33, "early update");
      tick(1);
      rdc(`TPMCH_OFF_VAL_LO, 8'h02, "no update on step");
      // set, clear and toggle each see one match at count 2
      for (int i = 0; i < 3; i++) begin
         wr(`TPMCH_OFF_CH_CTRL, cm[i]);
         wr(`TPMCH_OFF_CNT_LO, 8'h00);
         tick(3);
         chk(pin.out === ce[i], "compare pin action");
      end
      rdc(`TPMCH_OFF_CNT_LO, 8'h03, "fixed clock count");
      // divide by two: six fixed ticks make three counts
      wr(`TPMCH_OFF_PRESCALE, 8'h01);
      wr(`TPMCH_OFF_CNT_LO, 8'h00);
      tick(6);
      rdc(`TPMCH_OFF_CNT_LO, 8'h03, "prescaled count");
      wr(`TPMCH_OFF_PRESCALE, 8'h00);
      // external source: each synchronised rising edge counts once
      wr(`TPMCH_OFF_MAIN_CTRL, 8'h18);
      wr(`TPMCH_OFF_CNT_LO, 8'h00);
      repeat (3) begin
         ext <= 1'b1;
         idle(4);
         ext <= 1'b0;
         idle(4);
      end
      rdc(`TPMCH_OFF_CNT_LO, 8'h03, "external clock count");
      wr(`TPMCH_OFF_MAIN_CTRL, 8'h10);
      $display("compare test done");
   endtask
   task automatic t_capture;
      logic [7:0] cm [3] = '{8'h04, 8'h08, 8'h0C};
      for (int i = 0; i < 3; i++) begin
         clr(cm[i]);
         pin_to(1'b1);
         chk(flag === (i != 1), "rising edge flag");
         clr(cm[i]);
         chk(flag === 1'b0, "flag not cleared");
         pin_to(1'b0);
         chk(flag === (i != 0), "falling edge flag");
      end
      clr(8'h04);
      wr(`TPMCH_OFF_CNT_LO, 8'h00);
      tick(5);
      pin_to(1'b1);
      wr(`TPMCH_OFF_VAL_HI, 8'hFF);
      rdc(`TPMCH_OFF_VAL_HI, 8'h00, "capture write taken");
      tick(3);
      pin_to(1'b0);
      pin_to(1'b1);
      rdc(`TPMCH_OFF_VAL_LO, 8'h05, "read not coherent");
      rdc(`TPMCH_OFF_VAL_HI, 8'h00, "high byte");
      tick(3);
      pin_to(1'b0);
      pin_to(1'b1);
      rdc(`TPMCH_OFF_VAL_LO, 8'h08, "low not latched");
      rdc(`TPMCH_OFF_VAL_HI, 8'h00, "high byte");
      tick(2);
      pin_to(1'b0);
      pin_to(1'b1);
      dbg <= 1'b1;
      rdc(`TPMCH_OFF_VAL_LO, 8'h0D, "debug read not live");
      dbg <= 1'b0;
      rdc(`TPMCH_OFF_VAL_LO, 8'h0B, "latch moved in debug");
      $display("capture test done");
   endtask
   task automatic t_pwm;
      int         h;
      logic [7:0] mc [3] = '{8'h08, 8'h08, 8'h28};
      logic [7:0] cc [3] = '{8'h28, 8'h24, 8'h08};
      int         ph [3] = '{17, 17, 32};
      int         eh [3] = '{4, 13, 8};
      int         tl [3] = '{0, 0, 1};
      wr(`TPMCH_OFF_MOD_HI, 8'h00);
      wr(`TPMCH_OFF_MOD_LO, 8'h10);
      wr(`TPMCH_OFF_MAIN_CTRL, 8'h08);
      wr(`TPMCH_OFF_CH_CTRL, 8'h28);
      wr(`TPMCH_OFF_VAL_HI, 8'h00);
      wr(`TPMCH_OFF_VAL_LO, 8'h04);
      // let the pair reach its reload step before the loop rewrites the control register
      idle(20);
      // high time over one whole period does not depend on where counting starts
      for (int i = 0; i < 3; i++) begin
         wr(`TPMCH_OFF_MAIN_CTRL, mc[i]);
         wr(`TPMCH_OFF_CH_CTRL, cc[i]);
         idle(70);
         h = 0;
         repeat (ph[i]) begin
            @(posedge clk);
            #1;
            h += (pin.out === 1'b1);
         end
         chk(h >= eh[i] - tl[i] && h <= eh[i] + tl[i], "pwm duty");
      end
      wr(`TPMCH_OFF_CH_CTRL, 8'h00);
      idle(3);
      chk(pin.owned === 1'b0, "pin not released");
      $display("pwm test done");
   endtask
   task automatic final_report;
      $display("checks %0d fails %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   initial begin
      rst = 1'b1;
      req = '0;
      dbg = 1'b0;
      ft = 1'b0;
      ext = 1'b0;
      lvl = 1'b0;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      t_reset;
      t_compare;
      t_capture;
      t_pwm;
      final_report;
   end
   // the tests need under 2000 cycles; 20000 marks a hang
   initial begin
      #(25 * 20000);
      fails++;
      final_report;
   end
endmodule
`default_nettype wire
